// >>> logic/dio_edge_det.sv
// Two-flop synchroniser and selectable-polarity edge detector for one pin.
module dio_edge_det
  import dio_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  input  wire logic falling,
  output logic      edge_pulse
);

  // All state of the detector in one struct.
  typedef struct packed {
    logic meta;   // First synchroniser stage, read only by the second.
    logic sync;   // Second stage.
    logic prev;   // Last synchronised level.
    logic pulse;  // Registered edge pulse.
  } dio_edst_t;

  dio_edst_t st;
  dio_edst_t next_st;

  // Edge detection compares the second synchroniser stage with the stage after it only.
  always_comb begin
    next_st      = st;
    next_st.meta = pin;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
    // A steady level never produces a pulse, only a transition does.
    if (falling) begin
      next_st.pulse = st.prev & ~st.sync;
    end else begin
      next_st.pulse = ~st.prev & st.sync;
    end
  end

  // Register the state; reset values are constants.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign edge_pulse = st.pulse;

endmodule

// >>> logic/dio_pkg.sv
// Package of constants, types and register map for the discrete result I/O block.
package dio_pkg;

  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] DIO_OFS_CTRL   = 8'h00; // Edge select, compare enable, free run.
  localparam logic [7:0] DIO_OFS_OUTCFG = 8'h04; // Source and mode of the three outputs.
  localparam logic [7:0] DIO_OFS_PULSE  = 8'h08; // Pulse width in clock cycles.
  localparam logic [7:0] DIO_OFS_RESULT = 8'h0c; // Inspection result posting.
  localparam logic [7:0] DIO_OFS_CMD    = 8'h10; // History reset and fault clear strobes.
  localparam logic [7:0] DIO_OFS_STATUS = 8'h14; // Live state, read only.
  localparam logic [7:0] DIO_OFS_IRQST  = 8'h18; // Sticky event bits, write one to clear.
  localparam logic [7:0] DIO_OFS_IRQMSK = 8'h1c; // Interrupt mask, same layout.

  // Control register fields.
  localparam int DIO_CTRL_EDGE    = 0; // One selects the falling edge setting.
  localparam int DIO_CTRL_CMP     = 1; // Result string check enable.
  localparam int DIO_CTRL_FREERUN = 2; // Free running acquisition active.

  // Output configuration: four bits per output, source in [2:0], pulsed mode in [3].
  localparam int DIO_OCFG_W    = 4;
  localparam int DIO_NUM_OUT   = 3;

  // Result register fields.
  localparam int DIO_RES_DONE  = 0; // Inspection complete strobe.
  localparam int DIO_RES_FOUND = 1; // Configured barcode count was found.
  localparam int DIO_RES_CLEAN = 2; // Every barcode decoded without error.
  localparam int DIO_RES_CMPOK = 3; // Data comparison succeeded.
  localparam int DIO_RES_FATAL = 4; // Fatal fault detected.

  // Command register fields.
  localparam int DIO_CMD_HIST  = 0; // Statistics history reset.
  localparam int DIO_CMD_FCLR  = 1; // Fault flag clear command.

  // Interrupt event bits.
  localparam int DIO_EV_TRIG   = 0;
  localparam int DIO_EV_LEARN  = 1;
  localparam int DIO_EV_OVR    = 2;
  localparam int DIO_EV_FATAL  = 3;
  localparam int DIO_EV_DONE   = 4;
  localparam int DIO_EV_W      = 5;

  // Pulse width default: 50 ms at 250 MHz.
  localparam int  DIO_CLK_MHZ     = 250;
  localparam int  DIO_PULSE_MS    = 50;
  localparam int  DIO_PULSE_W     = 24;
  localparam logic [DIO_PULSE_W-1:0] DIO_PULSE_CYC =
    DIO_PULSE_W'(DIO_PULSE_MS * 1000 * DIO_CLK_MHZ);

  // Output sources.
  typedef enum logic [2:0] {
    DIO_SRC_OK, DIO_SRC_BAD, DIO_SRC_READ, DIO_SRC_ABSENT,
    DIO_SRC_MATCH, DIO_SRC_NOMATCH, DIO_SRC_OVR, DIO_SRC_FATAL
  } dio_src_t;

  // One output configuration.
  typedef struct packed {
    logic     pulsed;
    dio_src_t src;
  } dio_ocfg_t;

  // Reset configurations: out1 ok, out2 bad, out3 ok, all latched.
  localparam dio_ocfg_t DIO_OCFG1_RST = '{pulsed: 1'b0, src: DIO_SRC_OK};
  localparam dio_ocfg_t DIO_OCFG2_RST = '{pulsed: 1'b0, src: DIO_SRC_BAD};
  localparam dio_ocfg_t DIO_OCFG3_RST = '{pulsed: 1'b0, src: DIO_SRC_OK};

  // AHB-Lite transfer codes.
  localparam logic [1:0] DIO_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] DIO_HTRANS_SEQ    = 2'h3;

  // AHB-Lite slave inputs grouped.
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } dio_ahb_in_t;

  // Inspection result conditions.
  typedef struct packed {
    logic ok;
    logic bad;
    logic read;
    logic absent;
    logic match;
    logic nomatch;
  } dio_cond_t;

endpackage

// >>> logic/dio_result_io.sv
// Discrete input and result output logic with an AHB-Lite register slave.
//
// Overview of operation
// - Inputs act on transitions, never on levels.
// - Edge setting picks rising or falling detection.
// - Edge select resets by sourcing or sinking type.
// - Each output maps to one of eight sources.
// - Read means count found, all error free.
// - Code absent is count missed, never free running.
// - Without check, ok is read, bad absent.
// - With check, ok needs compare, else bad.
// - Match and no match need count found.
// - Trigger while busy sets overrun flag.
// - Only history reset clears overrun flag.
// - Fatal flag clears on history reset or command.
// - Output 1 resets ok latched, pulse 50 ms.
// - Latched output follows condition at each inspection.
// - Output 2 resets bad, output 3 ok.
//
// Register map, one aligned word per register, spare bits read zero.
// Offset 0x00 holds edge select, string check and free running.
// Offset 0x04 holds four bits per output, source low, pulsed on top.
// Offset 0x08 holds the pulse width in clock cycles.
// Offset 0x0c posts a result: done, found, clean, compare ok, fatal.
// Offset 0x10 takes history reset and fault clear strobes.
// Offset 0x14 shows busy, flags, conditions and output levels.
// Offset 0x18 holds sticky events, written one to clear.
// Offset 0x1c is the event mask of the same layout.
// The slave never inserts wait states and always answers OKAY.
// A pulse width of zero or one gives a single-cycle pulse.
module dio_result_io
  import dio_pkg::*;
#(
  parameter logic SINKING_UNIT = 1'b0  // One for a sinking-type unit.
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        trigger_pin,
  input  wire logic        learn_pin,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [2:0]       result_out,
  output logic             trigger_event,
  output logic             learn_event,
  output logic             irq
);

  // Complete block state.
  typedef struct packed {
    // Configuration written by software.
    logic                   edge_fall;   // Active edge select.
    logic                   cmp_en;      // Result string check enable.
    logic                   freerun;     // Free running acquisition.
    dio_ocfg_t [2:0]        ocfg;        // Output configurations.
    logic [DIO_PULSE_W-1:0] pulse_cyc;   // Pulse width in cycles.
    // Inspection tracking and sticky flags.
    logic                   busy;        // Inspection in progress.
    logic                   ovr;         // Sticky overrun flag.
    logic                   fatal;       // Sticky fatal fault flag.
    dio_cond_t              cond;        // Conditions of the last inspection.
    // Output drive.
    logic [2:0]             outs;        // Output levels.
    logic [2:0][DIO_PULSE_W-1:0] pcnt;   // Pulse down counters.
    // Interrupt logic.
    logic [DIO_EV_W-1:0]    irq_st;      // Sticky event bits.
    logic [DIO_EV_W-1:0]    irq_msk;     // Event mask.
    logic                   irq;         // Registered interrupt.
    logic                   trig_evt;    // Registered trigger event.
    logic                   learn_evt;   // Registered learn event.
    // Bus slave.
    logic                   dp_act;      // Data phase pending.
    logic                   dp_wr;       // Pending phase is a write.
    logic [7:0]             dp_addr;     // Pending word address.
    logic [31:0]            rdata;       // Read data.
    logic                   rdy;         // Registered ready, one out of reset.
    logic                   err;         // Registered response, always OKAY.
  } dio_state_t;

  // Present state and the next value that the comb process builds.
  dio_state_t st;
  dio_state_t next_st;
  // One-cycle edge pulses from the two detectors.
  logic       trig_edge;
  logic       learn_edge;
  dio_ahb_in_t bus;

  // Slave inputs gathered in one struct.
  assign bus = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite,
                 hsize: hsize, hwdata: hwdata, hready: hready};

  // Edge detectors for the two pins.
  // Each adds about four cycles from pin change to event pulse.
  dio_edge_det u_trig (
    .clk        (clk),
    .rst_n      (rst_n),
    .pin        (trigger_pin),
    .falling    (st.edge_fall),
    .edge_pulse (trig_edge)
  );

  // The learn input shares the edge select of the trigger input.
  dio_edge_det u_learn (
    .clk        (clk),
    .rst_n      (rst_n),
    .pin        (learn_pin),
    .falling    (st.edge_fall),
    .edge_pulse (learn_edge)
  );

  // Evaluate one output source against the current flags and conditions.
  // The overrun and fatal sources read the sticky flags, not a result.
  function automatic logic src_level(input dio_src_t s, input dio_cond_t c,
                                     input logic ovr, input logic fat);
    case (s)
      DIO_SRC_OK:      src_level = c.ok;
      DIO_SRC_BAD:     src_level = c.bad;
      DIO_SRC_READ:    src_level = c.read;
      DIO_SRC_ABSENT:  src_level = c.absent;
      DIO_SRC_MATCH:   src_level = c.match;
      DIO_SRC_NOMATCH: src_level = c.nomatch;
      DIO_SRC_OVR:     src_level = ovr;
      DIO_SRC_FATAL:   src_level = fat;
      default:         src_level = 1'b0;
    endcase
  endfunction

  // Derive all conditions from one inspection result.
  // Free running keeps code absent low, and bad too when unchecked.
  function automatic dio_cond_t eval_cond(input logic found, input logic clean,
                                          input logic cmpok, input logic cmp_en,
                                          input logic freerun);
    dio_cond_t c;
    c.read    = found & clean;
    c.absent  = ~found & ~freerun;
    c.match   = found & cmpok;
    c.nomatch = found & ~cmpok;
    if (cmp_en) begin
      c.ok  = c.read & cmpok;
      c.bad = ~c.ok;
    end else begin
      c.ok  = c.read;
      c.bad = c.absent;
    end
    return c;
  endfunction

  // Next-state logic for bus, flags, conditions and outputs.
  // Steps run in order: writes, tracking, flags, conditions, outputs,
  // events, then the next address phase; later steps read earlier ones.
  always_comb begin
    // Strobes and levels local to this evaluation.
    logic       wr;
    logic       hist;
    logic       fclr;
    logic       done;
    logic       ovr_set;
    logic       fat_set;
    logic [DIO_EV_W-1:0] ev;
    logic       lvl;
    logic       lvl_old;
    wr      = 1'b0;
    hist    = 1'b0;
    fclr    = 1'b0;
    done    = 1'b0;
    ovr_set = 1'b0;
    fat_set = 1'b0;
    ev      = '0;
    lvl     = 1'b0;
    lvl_old = 1'b0;
    next_st = st;
    // Ready and response never change: zero wait states, always OKAY.
    next_st.rdy = 1'b1;
    next_st.err = 1'b0;

    // Data phase: a write stores its data now, a read was fetched earlier.
    wr = st.dp_act & st.dp_wr;
    next_st.dp_act = 1'b0;
    if (wr) begin
      case (st.dp_addr)
        DIO_OFS_CTRL: begin
          next_st.edge_fall = bus.hwdata[DIO_CTRL_EDGE];
          next_st.cmp_en    = bus.hwdata[DIO_CTRL_CMP];
          next_st.freerun   = bus.hwdata[DIO_CTRL_FREERUN];
        end
        DIO_OFS_OUTCFG: begin
          for (int i = 0; i < DIO_NUM_OUT; i++) begin
            next_st.ocfg[i] = dio_ocfg_t'(bus.hwdata[i*DIO_OCFG_W +: DIO_OCFG_W]);
          end
        end
        // A new pulse width applies from the next pulse start.
        DIO_OFS_PULSE:  next_st.pulse_cyc = bus.hwdata[DIO_PULSE_W-1:0];
        // A posting is a strobe; only the conditions, busy, the fatal flag and the event bits it yields are kept.
        DIO_OFS_RESULT: begin
          done    = bus.hwdata[DIO_RES_DONE];
          fat_set = bus.hwdata[DIO_RES_FATAL];
        end
        // Command bits act once per write and are not stored.
        DIO_OFS_CMD: begin
          hist = bus.hwdata[DIO_CMD_HIST];
          fclr = bus.hwdata[DIO_CMD_FCLR];
        end
        DIO_OFS_IRQMSK: next_st.irq_msk = bus.hwdata[DIO_EV_W-1:0];
        default: ;
      endcase
    end

    // Inspection tracking: a trigger starts one, a posted result ends it.
    if (trig_edge && st.busy) begin
      ovr_set = 1'b1;
    end else if (trig_edge) begin
      next_st.busy = 1'b1;
    end
    // A trigger meeting a completion while idle starts the next one.
    if (done) begin
      next_st.busy = trig_edge & ~st.busy;
    end

    // Sticky flags: a set in the same cycle as a clear wins.
    // The fault clear command leaves the overrun flag alone.
    if (hist) begin
      next_st.ovr = 1'b0;
    end
    if (hist || fclr) begin
      next_st.fatal = 1'b0;
    end
    if (ovr_set) begin
      next_st.ovr = 1'b1;
    end
    if (fat_set) begin
      next_st.fatal = 1'b1;
    end

    // New conditions are taken only at inspection completion.
    if (done) begin
      next_st.cond = eval_cond(bus.hwdata[DIO_RES_FOUND], bus.hwdata[DIO_RES_CLEAN],
                               bus.hwdata[DIO_RES_CMPOK], st.cmp_en, st.freerun);
    end

    // Output drive per configured mode.
    // A later completion that shows the condition restarts a pulse.
    for (int i = 0; i < DIO_NUM_OUT; i++) begin
      lvl     = src_level(st.ocfg[i].src, next_st.cond, next_st.ovr, next_st.fatal);
      lvl_old = src_level(st.ocfg[i].src, st.cond, st.ovr, st.fatal);
      if (!st.ocfg[i].pulsed) begin
        // Latched level tracks the mapped source; it changes only when a result or the source mapping does, or a sticky flag for the overrun and fatal sources.
        next_st.outs[i] = lvl;
        next_st.pcnt[i] = '0;
      end else if (lvl && (done || !lvl_old)) begin
        // Pulse starts on a completion that shows the condition, or a flag rising.
        next_st.outs[i] = 1'b1;
        next_st.pcnt[i] = st.pulse_cyc;
      end else if (st.pcnt[i] > DIO_PULSE_W'(1)) begin
        next_st.pcnt[i] = st.pcnt[i] - DIO_PULSE_W'(1);
      end else begin
        next_st.outs[i] = 1'b0;
        next_st.pcnt[i] = '0;
      end
    end

    // Interrupt events; the event set wins over a write-one clear.
    // The interrupt uses the next status, so it adds no extra cycle.
    ev[DIO_EV_TRIG]  = trig_edge;
    ev[DIO_EV_LEARN] = learn_edge;
    ev[DIO_EV_OVR]   = ovr_set;
    ev[DIO_EV_FATAL] = fat_set;
    ev[DIO_EV_DONE]  = done;
    // Zero bits of a clear write leave their status bits alone.
    if (wr && st.dp_addr == DIO_OFS_IRQST) begin
      next_st.irq_st = st.irq_st & ~bus.hwdata[DIO_EV_W-1:0];
    end
    next_st.irq_st   = next_st.irq_st | ev;
    next_st.irq      = |(next_st.irq_st & next_st.irq_msk);
    next_st.trig_evt  = trig_edge;
    next_st.learn_evt = learn_edge;

    // Address phase: capture the transfer, prefetch read data.
    // Only the low address byte is decoded, so the map repeats.
    // A read right after a write to the same register sees the old value.
    if (bus.hsel && bus.hready && (bus.htrans == DIO_HTRANS_NONSEQ ||
                                   bus.htrans == DIO_HTRANS_SEQ)) begin
      next_st.dp_act  = 1'b1;
      next_st.dp_wr   = bus.hwrite;
      next_st.dp_addr = {bus.haddr[7:2], 2'h0};
      next_st.rdata   = '0;
      if (!bus.hwrite) begin
        case ({bus.haddr[7:2], 2'h0})
          DIO_OFS_CTRL: begin
            next_st.rdata[DIO_CTRL_EDGE]    = st.edge_fall;
            next_st.rdata[DIO_CTRL_CMP]     = st.cmp_en;
            next_st.rdata[DIO_CTRL_FREERUN] = st.freerun;
          end
          DIO_OFS_OUTCFG: begin
            for (int i = 0; i < DIO_NUM_OUT; i++) begin
              next_st.rdata[i*DIO_OCFG_W +: DIO_OCFG_W] = st.ocfg[i];
            end
          end
          DIO_OFS_PULSE:  next_st.rdata[DIO_PULSE_W-1:0] = st.pulse_cyc;
          // Status packs busy, flags, conditions and outputs from bit zero.
          DIO_OFS_STATUS: next_st.rdata[11:0] = {st.outs, st.cond, st.fatal, st.ovr, st.busy};
          DIO_OFS_IRQST:  next_st.rdata[DIO_EV_W-1:0] = st.irq_st;
          DIO_OFS_IRQMSK: next_st.rdata[DIO_EV_W-1:0] = st.irq_msk;
          default: ;
        endcase
      end
    end
  end

  // Configuration leaves reset at its defaults; flags and outputs at zero.
  // State register with constant reset values.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st           <= '0;
      st.edge_fall <= SINKING_UNIT;
      st.ocfg[0]   <= DIO_OCFG1_RST;
      st.ocfg[1]   <= DIO_OCFG2_RST;
      st.ocfg[2]   <= DIO_OCFG3_RST;
      st.pulse_cyc <= DIO_PULSE_CYC;
      st.rdy       <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register; the slave never waits.
  assign hrdata        = st.rdata;
  assign hreadyout     = st.rdy;
  assign hresp         = st.err;
  assign result_out    = st.outs;
  assign trigger_event = st.trig_evt;
  assign learn_event   = st.learn_evt;
  assign irq           = st.irq;

endmodule

// >>> tb/dio_chk.sv
// Concurrent checks on the ports of the discrete result I/O block.
module dio_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        trigger_pin,
  input wire logic        learn_pin,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [2:0]  result_out,
  input wire logic        trigger_event,
  input wire logic        learn_event,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] trig_quiet;  // Cycles the trigger pin has held one level, saturating.
  logic [3:0] learn_quiet; // Cycles the learn pin has held one level, saturating.
  logic       trig_d;      // Trigger pin one cycle ago.
  logic       learn_d;     // Learn pin one cycle ago.

  // Count how long each pin has been steady; eight quiet cycles outlast the synchroniser.
  always_ff @(posedge clk) begin
    trig_d      <= trigger_pin;
    learn_d     <= learn_pin;
    trig_quiet  <= (!rst_n || trigger_pin != trig_d) ? 4'h0 :
                   (trig_quiet == 4'hf) ? 4'hf : trig_quiet + 4'h1;
    learn_quiet <= (!rst_n || learn_pin != learn_d) ? 4'h0 :
                   (learn_quiet == 4'hf) ? 4'hf : learn_quiet + 4'h1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_ready_always: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered with an error");
  chk_trig_single: assert property (trigger_event |=> !trigger_event)
    else $error("trigger event lasted more than one cycle");
  chk_learn_single: assert property (learn_event |=> !learn_event)
    else $error("learn event lasted more than one cycle");
  chk_trig_level_quiet: assert property (trig_quiet >= 4'h8 |-> !trigger_event)
    else $error("trigger event without a pin transition");
  chk_learn_level_quiet: assert property (learn_quiet >= 4'h8 |-> !learn_event)
    else $error("learn event without a pin transition");
  chk_reset_outputs: assert property ($past(rst_n) == 1'b0 |-> result_out == 3'h0 && !irq)
    else $error("outputs not idle after reset");
  chk_reset_events: assert property ($past(rst_n) == 1'b0 |-> !trigger_event && !learn_event)
    else $error("input event straight after reset");
  chk_rdata_hold: assert property (!(hsel && hready && htrans[1]) |=> $stable(hrdata))
    else $error("read data moved without a new transfer");
endmodule

// >>> tb/dio_ctrl_model.sv
// Behavioural model of the external controller that drives both input pins.
module dio_ctrl_model
  import dio_pkg::*;
(
  input  wire logic clk,
  output logic      trigger_pin,
  output logic      learn_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins idle low, the inactive level for the rising edge setting.
  initial begin
    trigger_pin = 1'b0;
    learn_pin   = 1'b0;
  end

  // Change one pin just after an edge and hold it eight cycles, well over the four the block needs.
  task automatic drive(input logic sel, input logic lvl);
    @(posedge clk);
    if (sel) begin
      learn_pin <= lvl;
    end else begin
      trigger_pin <= lvl;
    end
    repeat (8) @(posedge clk);
  endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the discrete result I/O block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dio_pkg::*;
  logic        clk, rst_n, trigger_pin, learn_pin, hsel, hwrite, hreadyout, hresp, irq;
  logic        trigger_event, learn_event, rd_dp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, result_out;
  logic [31:0] exp_q[$], msk_q[$];   // Expected read data and compared bits.
  string       name_q[$];            // Name of each expected read.
  int          mismatches, comparisons, trig_cnt, learn_cnt, pulse_cnt, pulse_base;
  int          seed;
  logic [31:0] r;
  logic [5:0]  cv;                   // Expected {ok,bad,read,absent,match,nomatch}.

  dio_result_io dio_result_io_i (.clk(clk), .rst_n(rst_n), .trigger_pin(trigger_pin),
    .learn_pin(learn_pin), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .result_out(result_out),
    .trigger_event(trigger_event), .learn_event(learn_event), .irq(irq));
  dio_ctrl_model dio_ctrl_model_i (.clk(clk), .trigger_pin(trigger_pin), .learn_pin(learn_pin));

  always #2 clk = ~clk;

  // Compare one value; unknown bits never pass.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Print the counts and the verdict, then stop.
  task automatic wrap_up;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Wait for hready at a rising edge, bounded so a stuck slave ends the run.
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        mismatches++;
        wrap_up();
      end
      @(posedge clk);
    end
  endtask

  // One single word transfer; a read leaves its expectation in the queue for the monitor.
  task automatic bus(input logic [7:0] ofs, input logic wr, input logic [31:0] d,
                     input logic [31:0] msk, input string name);
    hsel <= 1'b1;
    haddr <= {24'h0, ofs};
    htrans <= DIO_HTRANS_NONSEQ;
    hwrite <= wr;
    if (!wr) begin
      exp_q.push_back(d & msk);
      msk_q.push_back(msk);
      name_q.push_back(name);
    end
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    wait_rdy();
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    bus(ofs, 1'b1, d, 32'h0, "");
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [31:0] e, input logic [31:0] m,
                    input string name);
    bus(ofs, 1'b0, e, m, name);
  endtask

  // Level of an output mapped to source s; the sticky flags are kept clear here.
  function automatic logic src_val(input logic [2:0] s, input logic [5:0] c);
    return (s < 3'h6) ? c[3'h5 - s] : 1'b0;
  endfunction

  // Monitor: the data phase of a read takes the oldest note; events and the high cycles of output 1 are counted.
  always @(posedge clk) begin
    if (rd_dp && hreadyout === 1'b1 && exp_q.size() > 0) begin
      check(name_q.pop_front(), hrdata & msk_q.pop_front(), exp_q.pop_front());
    end
    rd_dp <= (htrans == DIO_HTRANS_NONSEQ) && !hwrite && hreadyout === 1'b1;
    trig_cnt <= trig_cnt + int'(trigger_event === 1'b1);
    learn_cnt <= learn_cnt + int'(learn_event === 1'b1);
    pulse_cnt <= pulse_cnt + int'(result_out[0] === 1'b1);
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {hsel, hwrite, rd_dp} = 3'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    seed = 32'h0188;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(DIO_OFS_CTRL, 32'h0, 32'h7, "ctrl reset");
    rd(DIO_OFS_OUTCFG, 32'h010, 32'hfff, "outcfg reset");
    rd(DIO_OFS_PULSE, 32'(DIO_PULSE_CYC), 32'h00ffffff, "pulse reset");
    rd(8'h40, 32'h0, 32'hffffffff, "unmapped");
    $display("Test reset values done");
    dio_ctrl_model_i.drive(1'b0, 1'b1);
    dio_ctrl_model_i.drive(1'b0, 1'b0);
    dio_ctrl_model_i.drive(1'b0, 1'b1);
    check("trigger events", trig_cnt, 2);
    rd(DIO_OFS_STATUS, 32'h3, 32'h3, "busy and overrun");
    rd(DIO_OFS_IRQST, 32'h5, 32'h5, "irq status");
    wr(DIO_OFS_IRQMSK, 32'h4);
    repeat (3) @(posedge clk);
    check("irq raised", irq, 1);
    wr(DIO_OFS_IRQST, 32'h4);
    repeat (3) @(posedge clk);
    check("irq cleared", irq, 0);
    wr(DIO_OFS_RESULT, 32'h1);
    wr(DIO_OFS_CMD, 32'h2);
    rd(DIO_OFS_STATUS, 32'h2, 32'h3, "overrun kept");
    wr(DIO_OFS_CMD, 32'h1);
    rd(DIO_OFS_STATUS, 32'h0, 32'h2, "overrun cleared");
    $display("Test overrun done");
    dio_ctrl_model_i.drive(1'b0, 1'b0);
    wr(DIO_OFS_CTRL, 32'h1);
    dio_ctrl_model_i.drive(1'b1, 1'b1);
    check("learn on rise", learn_cnt, 0);
    dio_ctrl_model_i.drive(1'b1, 1'b0);
    check("learn on fall", learn_cnt, 1);
    check("trigger steady", trig_cnt, 2);
    $display("Test edge setting done");
    wr(DIO_OFS_OUTCFG, 32'h7);
    wr(DIO_OFS_RESULT, 32'h10);
    repeat (2) @(posedge clk);
    check("fatal output", result_out[0], 1);
    rd(DIO_OFS_STATUS, 32'h4, 32'h4, "fatal flag");
    wr(DIO_OFS_CMD, 32'h2);
    rd(DIO_OFS_STATUS, 32'h0, 32'h4, "fatal cleared");
    $display("Test fatal done");
    wr(DIO_OFS_PULSE, 32'h5);
    wr(DIO_OFS_OUTCFG, 32'h8);
    wr(DIO_OFS_CTRL, 32'h0);
    pulse_base = pulse_cnt;
    wr(DIO_OFS_RESULT, 32'h7);
    repeat (12) @(posedge clk);
    check("pulse width", pulse_cnt - pulse_base, 5);
    $display("Test pulsed output done");
    // Random inspections: 32 random mixes of found, clean, compare, check enable and free run.
    for (int i = 0; i < 32; i++) begin
      r = $random(seed);
      cv[3] = r[0] & r[1];
      cv[2] = !r[0] & !r[4];
      cv[5] = r[3] ? cv[3] & r[2] : cv[3];
      cv[4] = r[3] ? !cv[5] : cv[2];
      cv[1] = r[0] & r[2];
      cv[0] = r[0] & !r[2];
      wr(DIO_OFS_CTRL, {29'h0, r[4], r[3], 1'b0});
      wr(DIO_OFS_OUTCFG, {20'h0, 1'b0, r[13:11], 1'b0, r[10:8], 1'b0, r[7:5]});
      wr(DIO_OFS_RESULT, {28'h0, r[2], r[1], r[0], 1'b1});
      repeat (2) @(posedge clk);
      check("mapped outputs", result_out, {src_val(r[13:11], cv), src_val(r[10:8], cv),
            src_val(r[7:5], cv)});
      rd(DIO_OFS_STATUS, {23'h0, cv, 3'h0}, 32'h1f8, "conditions");
    end
    $display("Test random inspections done");
    repeat (5) @(posedge clk);
    wrap_up();
  end
endmodule

bind dio_result_io dio_chk dio_chk_i (.clk(clk), .rst_n(rst_n), .trigger_pin(trigger_pin),
  .learn_pin(learn_pin), .hsel(hsel), .htrans(htrans), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .result_out(result_out),
  .trigger_event(trigger_event), .learn_event(learn_event), .irq(irq));
